// ==== hpwg_pkg.sv ====
/*
  Constants and carrier types for the haptic PWM waveform generator.
  Assumes a 40 MHz system clock and a 32-bit APB register bus.

  // How it works
  // - Two drive schemes chosen by one bit
  // - Split: pin1 forward, pin2 reverse; else PWM/polarity
  // - PWM carrier fixed at 20 kHz
  // - Duty ramps 0 to 100 percent, triangular
  // - Split: positive half forward, negative reverse
  // - Polarity mode PWM carries magnitude only
  // - Polarity toggles every envelope half-cycle
  // - Off after reset, global enable starts
  // - Envelope frequency from resonance register, hertz
  // - Trigger on interval, button edge, host
  // - Fixed programmed frequency, no resonance tracking
  // - First pin not used as button echo
*/
package hpwg_pkg;

  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned CARRIER_HZ     = 20000;
  localparam int unsigned CARRIER_CYC    = CLK_HZ / CARRIER_HZ;
  localparam int unsigned PERIOD_W       = 11;
  localparam int unsigned FREQ_W         = 16;

  localparam logic [7:0]  OFS_CONFIG     = 8'h00;
  localparam logic [7:0]  OFS_FREQ       = 8'h04;
  localparam logic [7:0]  OFS_CMD        = 8'h08;
  localparam logic [7:0]  OFS_STATUS     = 8'h0C;

  localparam int unsigned BIT_ENABLE     = 0;
  localparam int unsigned BIT_SCHEME     = 1;
  localparam int unsigned BIT_CYCLES_LO  = 8;
  localparam int unsigned CYCLES_W       = 8;
  localparam int unsigned BIT_GO         = 0;

  localparam logic [15:0] RST_FREQ       = 16'h00C8;
  localparam logic [7:0]  RST_CYCLES     = 8'h02;
  localparam logic [31:0] BAD_READ       = 32'h0000_0000;

  typedef struct packed {
    logic                enable;
    logic                polarityScheme;
    logic [CYCLES_W-1:0] cycles;
    logic [FREQ_W-1:0]   freqHz;
  } hpwg_cfg_t;

  typedef struct packed {
    logic firstPin;
    logic secondPin;
  } hpwg_pins_t;

endpackage : hpwg_pkg

// ==== hpwg_carrier.sv ====
/*
  Free-running 20 kHz carrier counter and duty comparator.
  Assumes the duty value is stable across one carrier period.
*/
`timescale 1ns/1ps
module hpwg_carrier #(
  parameter int unsigned PERIOD = hpwg_pkg::CARRIER_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic                          clkEn,
  input  wire logic [hpwg_pkg::PERIOD_W-1:0] duty,
  output logic                               pwmOn,
  output logic                               periodStart
);
  logic [hpwg_pkg::PERIOD_W-1:0] count_ff;
  wire  lastCount = (count_ff == hpwg_pkg::PERIOD_W'(PERIOD - 1));

  always_ff @(posedge clock) begin
    if (reset) begin
      count_ff <= '0;
    end else if (clkEn) begin
      count_ff <= lastCount ? '0 : count_ff + 1'b1;
    end
  end

  assign pwmOn       = (count_ff < duty);
  assign periodStart = lastCount;
endmodule : hpwg_carrier

// ==== hpwg_ramp.sv ====
/*
  Envelope step accumulator: advances the triangle phase so that one
  full envelope repeats at the programmed frequency.
  Assumes one step per carrier period.
*/
`timescale 1ns/1ps
module hpwg_ramp (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic                        clkEn,
  input  wire logic                        clear,
  input  wire logic                        step,
  input  wire logic [hpwg_pkg::FREQ_W-1:0] freqHz,
  output logic [31:0]                      phase_ff,
  output logic                             wrap
);
  // Phase advance per carrier period = freq * 2^32 / 20000
  wire  [47:0] incWide = {freqHz, 32'h0000_0000} / 48'(hpwg_pkg::CARRIER_HZ);
  wire  [32:0] sum     = {1'b0, phase_ff} + {1'b0, incWide[31:0]};

  always_ff @(posedge clock) begin
    if (reset || (clkEn && clear)) begin
      phase_ff <= '0;
    end else if (clkEn && step) begin
      phase_ff <= sum[31:0];
    end
  end

  assign wrap = step && sum[32];
endmodule : hpwg_ramp

// ==== hpwg_top.sv ====
/*
  Haptic PWM waveform generator top: APB registers, trigger logic,
  triangular envelope and pin mapping for an external H-bridge.
  Assumes trigger inputs are asynchronous pulses or levels from outside.
*/
`timescale 1ns/1ps
module hpwg_top (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        intervalChange,
  input  wire logic        buttonActive,
  output logic             firstHapticPin,
  output logic             secondHapticPin,
  output logic             hapticBusy
);
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} hpwg_state_t;

  hpwg_pkg::hpwg_cfg_t cfg_ff;
  hpwg_pkg::hpwg_pins_t pins_ff;
  hpwg_state_t state_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        busy_ff;
  logic        hostGo_ff;
  logic [2:0]  intSync_ff;
  logic [2:0]  btnSync_ff;
  logic [hpwg_pkg::CYCLES_W-1:0] left_ff;
  logic        pwmOn;
  logic        periodStart;
  logic [31:0] phase;
  logic        wrap;

  // Register access
  wire apbAccess = psel && penable && !pready_ff;
  wire wrEn      = apbAccess && pwrite;
  wire rdEn      = apbAccess && !pwrite;
  wire selCfg    = (paddr == hpwg_pkg::OFS_CONFIG);
  wire selFreq   = (paddr == hpwg_pkg::OFS_FREQ);
  wire selCmd    = (paddr == hpwg_pkg::OFS_CMD);
  wire selStat   = (paddr == hpwg_pkg::OFS_STATUS);
  wire mapped    = selCfg || selFreq || selCmd || selStat;

  wire [31:0] rdMux =
    selCfg  ? {16'h0000, cfg_ff.cycles, 6'h00, cfg_ff.polarityScheme, cfg_ff.enable} :
    selFreq ? {16'h0000, cfg_ff.freqHz} :
    selStat ? {24'h000000, left_ff[5:0], pins_ff.secondPin, busy_ff} :
              hpwg_pkg::BAD_READ;

  always_ff @(posedge clock) begin
    if (reset) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (clkEn) begin
      pready_ff  <= apbAccess;
      pslverr_ff <= apbAccess && !mapped;
      prdata_ff  <= rdEn ? rdMux : '0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cfg_ff.enable         <= 1'b0;
      cfg_ff.polarityScheme <= 1'b0;
      cfg_ff.cycles         <= hpwg_pkg::RST_CYCLES;
      cfg_ff.freqHz         <= hpwg_pkg::RST_FREQ;
    end else if (clkEn && wrEn && selCfg) begin
      cfg_ff.enable         <= pwdata[hpwg_pkg::BIT_ENABLE];
      cfg_ff.polarityScheme <= pwdata[hpwg_pkg::BIT_SCHEME];
      cfg_ff.cycles         <= pwdata[hpwg_pkg::BIT_CYCLES_LO +: hpwg_pkg::CYCLES_W];
    end else if (clkEn && wrEn && selFreq) begin
      cfg_ff.freqHz         <= pwdata[hpwg_pkg::FREQ_W-1:0];
    end
  end

  // Trigger synchronisers and edge detection
  always_ff @(posedge clock) begin
    if (reset) begin
      intSync_ff <= '0;
      btnSync_ff <= '0;
      hostGo_ff  <= 1'b0;
    end else if (clkEn) begin
      intSync_ff <= {intSync_ff[1:0], intervalChange};
      btnSync_ff <= {btnSync_ff[1:0], buttonActive};
      hostGo_ff  <= wrEn && selCmd && pwdata[hpwg_pkg::BIT_GO];
    end
  end

  wire intEdge  = intSync_ff[2] ^ intSync_ff[1];
  wire btnEdge  = btnSync_ff[2] ^ btnSync_ff[1];
  wire trigger  = cfg_ff.enable && (intEdge || btnEdge || hostGo_ff);
  wire zeroFreq = (cfg_ff.freqHz == '0);

  // Envelope sequencer
  wire lastHalf = wrap && (left_ff <= 8'h01);
  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      left_ff  <= '0;
    end else if (clkEn) begin
      case (state_ff)
        ST_IDLE: begin
          if (trigger && !zeroFreq && cfg_ff.cycles != '0) begin
            state_ff <= ST_RUN;
            left_ff  <= cfg_ff.cycles;
          end
        end
        ST_RUN: begin
          if (!cfg_ff.enable || lastHalf) begin
            state_ff <= ST_IDLE;
            left_ff  <= '0;
          end else if (trigger) begin
            left_ff  <= cfg_ff.cycles;
          end else if (wrap) begin
            left_ff  <= left_ff - 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  wire running = (state_ff == ST_RUN);

  hpwg_ramp u_ramp (
    .clock    (clock),
    .reset    (reset),
    .clkEn    (clkEn),
    .clear    (!running),
    .step     (running && periodStart),
    .freqHz   (cfg_ff.freqHz),
    .phase_ff (phase),
    .wrap     (wrap)
  );

  // Triangle: phase[31] picks half (sign), phase[30] rises/falls, magnitude 0..100%
  // Magnitude and sign both come from the live phase, so they switch together
  wire [30:0] fracLo  = {1'b0, phase[29:0]};
  wire [30:0] frac    = phase[30] ? (31'h4000_0000 - fracLo) : fracLo;
  wire [42:0] magWide = frac * 12'(hpwg_pkg::CARRIER_CYC);
  wire [hpwg_pkg::PERIOD_W-1:0] magDuty = magWide[30 +: hpwg_pkg::PERIOD_W];
  wire negHalf = phase[31];
  // Phase only steps at periodStart, so the duty holds for a whole carrier period
  wire [hpwg_pkg::PERIOD_W-1:0] dutyNow = running ? magDuty : '0;

  hpwg_carrier u_carrier (
    .clock       (clock),
    .reset       (reset),
    .clkEn       (clkEn),
    .duty        (dutyNow),
    .pwmOn       (pwmOn),
    .periodStart (periodStart)
  );

  // Pin mapping; the first pin is owned by haptics only, never a button echo
  wire drive    = running && cfg_ff.enable && pwmOn;
  wire fwdPwm   = drive && !negHalf;
  wire revPwm   = drive && negHalf;
  hpwg_pkg::hpwg_pins_t nxt_pins;
  assign nxt_pins.firstPin  = cfg_ff.polarityScheme ? drive : fwdPwm;
  assign nxt_pins.secondPin = cfg_ff.polarityScheme ? (running && negHalf) : revPwm;

  always_ff @(posedge clock) begin
    if (reset) begin
      pins_ff <= '0;
      busy_ff <= 1'b0;
    end else if (clkEn) begin
      pins_ff <= nxt_pins;
      busy_ff <= running;
    end
  end

  assign firstHapticPin  = pins_ff.firstPin;
  assign secondHapticPin = pins_ff.secondPin;
  assign hapticBusy      = busy_ff;
  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
endmodule : hpwg_top

// ==== hpwg_hbridge_model.sv ====
/*
  H-bridge partner: tallies drive cycles of each polarity on the haptic pins.
  Assumes the bench tells it which drive scheme is selected.
*/
`timescale 1ns/1ps
module hpwg_hbridge_model (
  input  wire logic clock,
  input  wire logic clear,
  input  wire logic polarityScheme,
  input  wire logic firstHapticPin,
  input  wire logic secondHapticPin,
  output int        posCount,
  output int        negCount
);
  // Split: one leg per sign; polarity: magnitude plus sign line
  always @(posedge clock) begin
    if (clear) begin
      posCount <= 0;
      negCount <= 0;
    end else if (polarityScheme) begin
      posCount <= posCount + int'(firstHapticPin && !secondHapticPin);
      negCount <= negCount + int'(firstHapticPin && secondHapticPin);
    end else begin
      posCount <= posCount + int'(firstHapticPin);
      negCount <= negCount + int'(secondHapticPin);
    end
  end
endmodule : hpwg_hbridge_model

// ==== hpwg_top_assertions.sv ====
/*
  Checker for hpwg_top: bus timing, idle pins and split-mode overlap.
  Assumes clkEn stays high; bound to every hpwg_top instance.
*/
`timescale 1ns/1ps
module hpwg_top_assertions (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        firstHapticPin,
  input wire logic        secondHapticPin,
  input wire logic        hapticBusy
);
  logic enableFf;
  logic schemeFf;
  wire  cfgWrite = psel && penable && pwrite && !pready && clkEn && paddr == hpwg_pkg::OFS_CONFIG;
  wire  mapped = paddr inside {hpwg_pkg::OFS_CONFIG, hpwg_pkg::OFS_FREQ,
                               hpwg_pkg::OFS_CMD, hpwg_pkg::OFS_STATUS};
  always_ff @(posedge clock) begin
    if (reset) begin
      enableFf <= 1'b0;
      schemeFf <= 1'b0;
    end else if (cfgWrite) begin
      enableFf <= pwdata[hpwg_pkg::BIT_ENABLE];
      schemeFf <= pwdata[hpwg_pkg::BIT_SCHEME];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence setupThenAccess;
    psel && !penable ##1 psel && penable;
  endsequence
  chk_apb_wait: assert property (setupThenAccess |-> !pready ##1 pready)
    else $error("answer not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  chk_unused_zero: assert property (pready && !pwrite && paddr == hpwg_pkg::OFS_CONFIG
    |-> prdata[31:16] == 16'h0000 && prdata[7:2] == 6'h00)
    else $error("unused config bits not zero");
  chk_no_shoot: assert property (!schemeFf |-> !(firstHapticPin && secondHapticPin))
    else $error("both legs driven high");
  chk_off_low: assert property ((!enableFf)[*3] |-> !firstHapticPin && !secondHapticPin
    && !hapticBusy)
    else $error("output active while disabled");
  chk_idle_low: assert property ((!hapticBusy)[*3] |-> !firstHapticPin && !secondHapticPin)
    else $error("pins active while idle");
endmodule : hpwg_top_assertions
bind hpwg_top hpwg_top_assertions u_hpwg_top_assertions (.clock(clock), .reset(reset),
  .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .firstHapticPin(firstHapticPin), .secondHapticPin(secondHapticPin), .hapticBusy(hapticBusy));

// ==== hpwg_top_bench.sv ====
/*
  Bench for the haptic generator: bus tasks, scoreboard, trigger runs.
  Assumes hpwg_top, the H-bridge model and the bound checker.
*/
`timescale 1ns/1ps
`define CMP(a, b) begin testsRun++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); end end
module hpwg_top_bench;
  logic        clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic        intervalChange = 0, buttonActive = 0, clr = 1, scheme = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, firstPin, secondPin, busy;
  logic [32:0] note, expQ[$];
  int          errors = 0, testsRun = 0, seed = 29, posCnt, negCnt, freq, n;
  always #12.5 clock = ~clock;
  hpwg_top u_hpwg_top (.clock(clock), .reset(reset), .clkEn(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .intervalChange(intervalChange),
    .buttonActive(buttonActive), .firstHapticPin(firstPin), .secondHapticPin(secondPin),
    .hapticBusy(busy));
  hpwg_hbridge_model u_hpwg_hbridge_model (.clock(clock), .clear(clr), .polarityScheme(scheme),
    .firstHapticPin(firstPin), .secondHapticPin(secondPin), .posCount(posCnt),
    .negCount(negCnt));
  task automatic tally_and_finish;
    if (errors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] exp);
    int k;
    k = 0;
    expQ.push_back(exp);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic waitBusy(input logic v, input int lim);
    n = 0;
    while (busy !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    `CMP(busy, v)
  endtask : waitBusy
  // Scoreboard: each answer against the oldest note
  always @(posedge clock) begin
    if (pready === 1'b1) begin
      note = expQ.pop_front();
      `CMP({pslverr, prdata}, note)
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, hpwg_pkg::OFS_CONFIG, 32'h0000_0000, 33'h0_0000_0200);
    apb(1'b0, hpwg_pkg::OFS_FREQ, 32'h0000_0000, 33'h0_0000_00C8);
    apb(1'b0, hpwg_pkg::OFS_STATUS, 32'h0000_0000, 33'h0_0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, 8'h22, 32'hFFFF_FFFF, 33'h1_0000_0000);
    intervalChange <= 1'b1;
    repeat (10) @(posedge clock);
    `CMP(busy, 1'b0)
    for (int t = 0; t < 4; t++) begin
      freq = 2500 + ($random(seed) & 1023);
      scheme <= t[0];
      apb(1'b1, hpwg_pkg::OFS_FREQ, 32'(freq), 33'h0_0000_0000);
      apb(1'b0, hpwg_pkg::OFS_FREQ, 32'h0000_0000, {1'b0, 32'(freq)});
      apb(1'b1, hpwg_pkg::OFS_CONFIG, {16'h0000, 8'h01, 6'h00, t[0], 1'b1}, 33'h0_0000_0000);
      clr <= 1'b0;
      case (t)
        0: apb(1'b1, hpwg_pkg::OFS_CMD, 32'h0000_0001, 33'h0_0000_0000);
        1: intervalChange <= ~intervalChange;
        default: buttonActive <= ~buttonActive;
      endcase
      waitBusy(1'b1, 20);
      waitBusy(1'b0, 60000);
      `CMP(posCnt > 0 && negCnt > 0, 1'b1)
      n = posCnt + negCnt - int'(hpwg_pkg::CLK_HZ) / (2 * freq);
      n = n < 0 ? -n : n;
      `CMP(n <= 2 * int'(hpwg_pkg::CARRIER_CYC), 1'b1)
      clr <= 1'b1;
    end
    apb(1'b1, hpwg_pkg::OFS_CMD, 32'h0000_0001, 33'h0_0000_0000);
    repeat (3000) @(posedge clock);
    apb(1'b1, hpwg_pkg::OFS_CONFIG, 32'h0000_0000, 33'h0_0000_0000);
    repeat (3) @(posedge clock);
    `CMP({firstPin, secondPin, busy}, 3'b000)
    tally_and_finish();
  end
  initial begin
    #(25 * 95000);
    errors++;
    tally_and_finish();
  end
endmodule : hpwg_top_bench
